// ### verilog/llerr_status.sv
/*
 * Per-lane alignment, disparity and invalid-code status for two links of
 * eight lanes, read over an AHB-Lite slave with a paged link selection.
 * Assumes lane inputs synchronous to hclk; error inputs are one-cycle
 * pulses per detected error.
 */
`timescale 1ns/1ps

// Contract
// - one alignment bit per lane at its lane number, 1 aligned, 0 failed
// - disparity flag register at 0x46D, bit 1 when count reaches threshold
// - invalid-code flag register at 0x46E, bit 1 when count reaches threshold
// - one 8-bit threshold; flag 0 below it, 1 at or above it
// - flags shown are those of the link chosen by the page at 0x300
// - all per-lane flags read-only, writes ignored, zero after reset
// - alignment bits at 0x46C, lane 7 at bit 7 down to lane 0 at bit 0
module llerr_status
   import llerr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire llerr_link_in_t [NUM_LINKS-1:0] links
);

   llerr_state_t s_q;
   llerr_state_t s_d;

   logic [IDX_W-1:0] idx;
   logic addr_ok;
   logic ap;
   logic rd_ap;

   assign idx = haddr[ADDR_LSB +: IDX_W];
   assign addr_ok = (haddr[31:IDX_W+ADDR_LSB] == '0);
   assign ap = hsel && htrans[HTRANS_ACTIVE] && hready;
   assign rd_ap = ap && !hwrite && addr_ok;

   always_comb begin
      logic [NUM_LINKS-1:0] clr;
      logic [IRQ_W-1:0] w1c;
      logic [IRQ_W-1:0] ev;
      clr = '0;
      w1c = '0;
      ev = '0;
      s_d = s_q;

      // data phase of a write; flag registers take no write
      if (s_q.wr_pend) begin
         case (s_q.wr_idx)
            IDX_LINK_PAGE: s_d.link_page = hwdata[0];
            IDX_THRESH: s_d.thresh = hwdata[CNT_W-1:0];
            IDX_CNT_CLR: clr = hwdata[NUM_LINKS-1:0];
            IDX_IRQ_STAT: w1c = hwdata[IRQ_W-1:0];
            IDX_IRQ_MASK: s_d.irq_mask = hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      for (int l = 0; l < NUM_LINKS; l++) begin
         for (int i = 0; i < NUM_LANES; i++) begin
            s_d.align[l][i] = links[l].aligned[i];
            // saturating counts, frozen while the link is idle
            if (clr[l]) begin
               s_d.disp_cnt[l][i] = '0;
               s_d.nit_cnt[l][i] = '0;
            end else if (links[l].running) begin
               if (links[l].disp_err[i] && s_q.disp_cnt[l][i] != CNT_MAX)
                  s_d.disp_cnt[l][i] = s_q.disp_cnt[l][i] + CNT_ONE;
               if (links[l].nit_err[i] && s_q.nit_cnt[l][i] != CNT_MAX)
                  s_d.nit_cnt[l][i] = s_q.nit_cnt[l][i] + CNT_ONE;
            end
            s_d.disp_flag[l][i] =
               (s_q.disp_cnt[l][i] >= s_q.thresh);
            s_d.nit_flag[l][i] =
               (s_q.nit_cnt[l][i] >= s_q.thresh);
         end
      end

      // events: any lane losing alignment, any flag rising
      ev[IRQ_ALIGN_LOST] = |(s_q.align & ~s_d.align);
      ev[IRQ_DISP] = |(s_d.disp_flag & ~s_q.disp_flag);
      ev[IRQ_NIT] = |(s_d.nit_flag & ~s_q.nit_flag);
      // a new event wins over a clear in the same cycle
      s_d.irq_stat = (s_q.irq_stat & ~w1c) | ev;
      s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

      // address phase; zero wait states, always OKAY
      s_d.wr_pend = ap && hwrite && addr_ok;
      s_d.wr_idx = idx;
      s_d.hreadyout = 1'b1;
      s_d.hresp = 1'b0;
      s_d.hrdata = '0;
      // read from next values so a write just before is seen
      if (rd_ap) begin
         case (idx)
            IDX_LINK_PAGE: s_d.hrdata[0] = s_d.link_page;
            IDX_ALIGN:
               s_d.hrdata[NUM_LANES-1:0] =
                  s_d.align[s_d.link_page];
            IDX_DISP:
               s_d.hrdata[NUM_LANES-1:0] =
                  s_d.disp_flag[s_d.link_page];
            IDX_NIT:
               s_d.hrdata[NUM_LANES-1:0] =
                  s_d.nit_flag[s_d.link_page];
            IDX_THRESH: s_d.hrdata[CNT_W-1:0] = s_d.thresh;
            IDX_IRQ_STAT: s_d.hrdata[IRQ_W-1:0] = s_d.irq_stat;
            IDX_IRQ_MASK: s_d.hrdata[IRQ_W-1:0] = s_d.irq_mask;
            default: s_d.hrdata = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.hreadyout <= 1'b1;
         s_q.thresh <= THRESH_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata = s_q.hrdata;
   assign hreadyout = s_q.hreadyout;
   assign hresp = s_q.hresp;
   assign irq = s_q.irq;

   // helper terms for the checks below
   logic nit_ge_1_7;
   logic disp_ge_0_0;
   logic page_q;
   logic clr_wr;
   assign nit_ge_1_7 = (s_q.nit_cnt[1][7] >= s_q.thresh);
   assign disp_ge_0_0 = (s_q.disp_cnt[0][0] >= s_q.thresh);
   assign page_q = s_q.link_page;
   assign clr_wr = s_q.wr_pend && (s_q.wr_idx == IDX_CNT_CLR);

   // event terms, seen in the cycle before the status bit updates
   logic disp_rise;
   logic align_drop;
   logic stat_wr;
   assign disp_rise = |(s_d.disp_flag & ~s_q.disp_flag);
   assign align_drop = |(s_q.align & ~s_d.align);
   assign stat_wr = s_q.wr_pend && (s_q.wr_idx == IDX_IRQ_STAT);

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_align_paged_read: assert property (
      rd_ap && idx == IDX_ALIGN && !s_q.wr_pend
      |=> hrdata[NUM_LANES-1:0] == s_q.align[$past(page_q)])
      else $error("alignment read does not match selected link");

   a_disp_paged_read: assert property (
      rd_ap && idx == IDX_DISP && !s_q.wr_pend
      |=> hrdata[NUM_LANES-1:0] == s_q.disp_flag[$past(page_q)]
          && hrdata[31:NUM_LANES] == '0)
      else $error("disparity flag read mismatch");

   a_nit_paged_read: assert property (
      rd_ap && idx == IDX_NIT && !s_q.wr_pend
      |=> hrdata[NUM_LANES-1:0] == s_q.nit_flag[$past(page_q)])
      else $error("invalid-code flag read mismatch");

   a_thresh_compare: assert property (
      ##1 (s_q.nit_flag[1][7] == $past(nit_ge_1_7))
          && (s_q.disp_flag[0][0] == $past(disp_ge_0_0)))
      else $error("flag disagrees with threshold comparison");

   a_page_select: assert property (
      s_q.wr_pend && s_q.wr_idx == IDX_LINK_PAGE
      |=> s_q.link_page == $past(hwdata[0]))
      else $error("link page write not taken");

   a_flags_readonly: assert property (
      s_q.wr_pend && (s_q.wr_idx == IDX_DISP || s_q.wr_idx == IDX_NIT
         || s_q.wr_idx == IDX_ALIGN)
      |=> $stable(s_q.thresh) && $stable(s_q.link_page)
          && $stable(s_q.irq_mask))
      else $error("write to a read-only flag register had an effect");

   a_align_bit_order: assert property (
      rd_ap && idx == IDX_ALIGN && !s_q.wr_pend && !s_q.link_page
      |=> hrdata[NUM_LANES-1] == s_q.align[0][NUM_LANES-1]
          && hrdata[0] == s_q.align[0][0] && hrdata[31:NUM_LANES] == '0)
      else $error("alignment bit order wrong");

   a_cnt_increment: assert property (
      links[0].running && links[0].disp_err[0] && !clr_wr
      && s_q.disp_cnt[0][0] != CNT_MAX
      |=> s_q.disp_cnt[0][0] == $past(s_q.disp_cnt[0][0]) + CNT_ONE)
      else $error("error counter did not increment");

   a_cnt_saturate: assert property (
      s_q.nit_cnt[1][7] == CNT_MAX && !clr_wr
      |=> s_q.nit_cnt[1][7] == CNT_MAX)
      else $error("error counter wrapped past saturation");

   a_nit_increment: assert property (
      links[1].running && links[1].nit_err[7] && !clr_wr
      && s_q.nit_cnt[1][7] != CNT_MAX
      |=> s_q.nit_cnt[1][7] == $past(s_q.nit_cnt[1][7]) + CNT_ONE)
      else $error("invalid-code counter did not increment");

   a_cnt_frozen_idle: assert property (
      !links[1].running && !clr_wr
      |=> $stable(s_q.nit_cnt[1][7]) && $stable(s_q.disp_cnt[1][0]))
      else $error("counter moved while link idle");

   a_cnt_clear: assert property (
      clr_wr && hwdata[0]
      |=> s_q.disp_cnt[0][0] == '0 && s_q.nit_cnt[0][7] == '0)
      else $error("counter clear not applied");

   a_flag_below: assert property (
      s_q.disp_cnt[1][3] < s_q.thresh
      |=> !s_q.disp_flag[1][3])
      else $error("flag set below threshold");

   a_flag_at_or_above: assert property (
      s_q.nit_cnt[0][2] >= s_q.thresh
      |=> s_q.nit_flag[0][2])
      else $error("flag clear at or above threshold");

   a_align_follows: assert property (
      ##1 s_q.align[0] == $past(links[0].aligned)
          && s_q.align[1] == $past(links[1].aligned))
      else $error("alignment status does not follow lanes");

   a_page_read: assert property (
      rd_ap && idx == IDX_LINK_PAGE && !s_q.wr_pend
      |=> hrdata == {31'h0, $past(page_q)})
      else $error("link page read mismatch");

   a_wronly_reads_zero: assert property (
      rd_ap && idx == IDX_CNT_CLR
      |=> hrdata == '0)
      else $error("write-only register read not zero");

   a_hrdata_idle: assert property (
      !rd_ap
      |=> hrdata == '0)
      else $error("read data outside a read data phase");

   a_bus_okay: assert property (
      hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus response not okay and ready");

   a_irq_level: assert property (
      irq == |(s_q.irq_stat & s_q.irq_mask))
      else $error("interrupt level disagrees with status and mask");

   a_stat_set_wins: assert property (
      stat_wr && hwdata[IRQ_DISP] && disp_rise
      |=> s_q.irq_stat[IRQ_DISP])
      else $error("new event lost to a clear");

   a_stat_w1c: assert property (
      stat_wr && hwdata[IRQ_DISP] && !disp_rise
      |=> !s_q.irq_stat[IRQ_DISP])
      else $error("status bit not cleared by a one");

   a_align_lost_stat: assert property (
      align_drop
      |=> s_q.irq_stat[IRQ_ALIGN_LOST])
      else $error("alignment loss not recorded");

   c_cnt_cleared: cover property (clr_wr && hwdata[0]);
   c_stat_cleared: cover property (stat_wr && hwdata[IRQ_DISP]);
   c_read_page_one: cover property (
      rd_ap && idx == IDX_ALIGN && s_q.link_page ##1 hrdata != '0);
   c_irq_raised: cover property ($rose(irq));
   c_cnt_saturated: cover property (s_q.disp_cnt[0][0] == CNT_MAX);

endmodule : llerr_status

// ### include/llerr_pkg.sv
/*
 * Constants and carrier types for the per-lane link error status block.
 * Assumes a 32-bit AHB-Lite bus with word-aligned register indexes.
 */
package llerr_pkg;
   localparam int NUM_LANES = 8;
   localparam int NUM_LINKS = 2;
   localparam int CNT_W = 8;
   localparam int IDX_W = 12;
   localparam int ADDR_LSB = 2;
   localparam int IRQ_W = 3;
   localparam int HTRANS_ACTIVE = 1;

   // register indexes; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 12'h300;
   localparam logic [IDX_W-1:0] IDX_ALIGN = 12'h46C;
   localparam logic [IDX_W-1:0] IDX_DISP = 12'h46D;
   localparam logic [IDX_W-1:0] IDX_NIT = 12'h46E;
   localparam logic [IDX_W-1:0] IDX_THRESH = 12'h480;
   localparam logic [IDX_W-1:0] IDX_CNT_CLR = 12'h481;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h482;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h483;

   localparam logic [CNT_W-1:0] THRESH_RESET = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // interrupt status bit positions
   localparam int IRQ_ALIGN_LOST = 0;
   localparam int IRQ_DISP = 1;
   localparam int IRQ_NIT = 2;

   typedef struct packed {
      logic running;
      logic [NUM_LANES-1:0] aligned;
      logic [NUM_LANES-1:0] disp_err;
      logic [NUM_LANES-1:0] nit_err;
   } llerr_link_in_t;

   typedef logic [NUM_LINKS-1:0][NUM_LANES-1:0][CNT_W-1:0] llerr_cnt_t;
   typedef logic [NUM_LINKS-1:0][NUM_LANES-1:0] llerr_flags_t;

   typedef struct packed {
      logic wr_pend;
      logic [IDX_W-1:0] wr_idx;
      logic link_page;
      logic [CNT_W-1:0] thresh;
      logic [IRQ_W-1:0] irq_mask;
      logic [IRQ_W-1:0] irq_stat;
      llerr_flags_t align;
      llerr_cnt_t disp_cnt;
      llerr_cnt_t nit_cnt;
      llerr_flags_t disp_flag;
      llerr_flags_t nit_flag;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic irq;
   } llerr_state_t;
endpackage : llerr_pkg

// ### sim/llerr_link_model.sv
/*
 * Transmitter-side model: lane alignment levels and error pulses per link.
 * Assumes its tasks are called from the bench in the hclk domain.
 */
`timescale 1ns/1ps
module llerr_link_model
   import llerr_pkg::*;
(
   input wire logic hclk,
   output llerr_link_in_t [NUM_LINKS-1:0] links
);
   initial links = '0;

   // link starts running with the given lane alignment
   task automatic set_align(input int l, input logic [7:0] v);
      @(posedge hclk);
      links[l].running <= 1'b1;
      links[l].aligned <= v;
   endtask : set_align

   // n single-cycle error pulses on one lane, spaced by a quiet cycle
   task automatic pulse(input int l, input bit lane_invalid_code_fault, input int ln, input int n);
      repeat (n) begin
         @(posedge hclk);
         if (lane_invalid_code_fault) links[l].nit_err[ln] <= 1'b1;
         else links[l].disp_err[ln] <= 1'b1;
         @(posedge hclk);
         links[l].nit_err <= '0;
         links[l].disp_err <= '0;
      end
   endtask : pulse
endmodule : llerr_link_model

// ### sim/llerr_status_tb.sv
/*
 * Self-checking bench for the lane error status block.
 * Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
 */
`timescale 1ns/1ps
module llerr_status_tb;
   import llerr_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic rd_ph = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq;
   llerr_link_in_t [NUM_LINKS-1:0] links;
   logic [31:0] exp_q[$];
   logic [11:0] ro[3] = '{IDX_ALIGN, IDX_DISP, IDX_NIT};
   logic [7:0] a0, a1;
   int err_count = 0;
   int checks = 0;
   int ln;

   always #25 hclk = ~hclk;

   llerr_status i_llerr_status(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .links(links));
   llerr_link_model i_llerr_link_model(.hclk(hclk), .links(links));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("err_count %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   // one single transfer; hangs are cut by the watchdog
   task automatic ahb(input logic [11:0] idx, input logic wr,
                      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {18'h0, idx, 2'h0};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : ahb

   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      ahb(idx, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
      exp_q.push_back(exp);
      ahb(idx, 1'b0, 32'h0);
   endtask : rd

   // read data phase follows an accepted read address phase
   always @(posedge hclk) if (hreadyout) rd_ph <= hsel & htrans[1] & ~hwrite;
   always @(negedge hclk) begin
      if (rd_ph && exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
      if (rd_ph) chk({31'h0, hresp}, 32'h0);
   end

   initial begin
      #100us;
      err_count++;
      give_verdict();
   end

   initial begin
      ln = $urandom(32'hF9AE2172);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ro[i]) begin
         wr(ro[i], 32'hFFFFFFFF);
         rd(ro[i], 32'h0);
      end
      rd(IDX_THRESH, 32'hFF);
      rd(12'h7FF, 32'h0);
      a0 = 8'($urandom);
      a1 = 8'($urandom);
      ln = $urandom_range(7);
      i_llerr_link_model.set_align(0, a0);
      i_llerr_link_model.set_align(1, a1);
      rd(IDX_ALIGN, {24'h0, a0});
      wr(IDX_LINK_PAGE, 32'h1);
      rd(IDX_ALIGN, {24'h0, a1});
      wr(IDX_IRQ_MASK, 32'h2);
      wr(IDX_THRESH, 32'h3);
      i_llerr_link_model.pulse(1, 1'b0, ln, 2);
      rd(IDX_DISP, 32'h0);
      i_llerr_link_model.pulse(1, 1'b0, ln, 1);
      repeat (2) @(posedge hclk);
      rd(IDX_DISP, 32'h1 << ln);
      rd(IDX_NIT, 32'h0);
      @(negedge hclk) chk({31'h0, irq}, 32'h1);
      wr(IDX_LINK_PAGE, 32'h0);
      rd(IDX_DISP, 32'h0);
      i_llerr_link_model.pulse(0, 1'b1, ln, 3);
      repeat (2) @(posedge hclk);
      rd(IDX_NIT, 32'h1 << ln);
      rd(IDX_IRQ_STAT, 32'h6);
      wr(IDX_CNT_CLR, 32'h1);
      rd(IDX_NIT, 32'h0);
      wr(IDX_IRQ_STAT, 32'h7);
      rd(IDX_IRQ_STAT, 32'h0);
      @(negedge hclk) chk({31'h0, irq}, 32'h0);
      give_verdict();
   end
endmodule : llerr_status_tb
